/* File: src/bvlp_arbiter.sv */
// Arbiter between background functions and timer-driven low-power conditions
//
// Summary of operation
// - Hold the two-bit precedence code.
// - Code zero behaves as background priority.
// - Background priority wakes from timer low power.
// - Host command suspends running background function.
// - Run every initiated background function, any order.
// - After background work, enter highest expired timer.
// - Background priority finishes work before timer condition.
// - Low-power priority never wakes for background work.
// - Low-power priority runs work only when idle.
// - Low-power priority: timer expiry suspends work, enters.
module bvlp_arbiter #(
   parameter int N_BG  = bvlp_pkg::BG_FUNCS_DEF,  // Background function sources
   parameter int N_TMR = bvlp_pkg::TIMERS_DEF     // Power condition timers, bit 0 highest
) (
   input  wire logic             CLK,                       // 200 MHz clock
   input  wire logic             ARST_N,                    // Async reset, active low
   input  wire logic [1:0]       BG_POWER_PRECEDENCE_CODE,  // Precedence code setting
   input  wire logic [N_BG-1:0]  BG_TRIG,                   // Background trigger pulses
   input  wire logic [N_BG-1:0]  BG_EN,                     // Background function enables
   input  wire logic             BG_DONE,                   // Running function completed
   input  wire logic [N_TMR-1:0] TMR_EXPIRED,               // Timer expiry pulses
   input  wire logic             HOST_CMD,                  // Host command being processed
   input  wire logic             HOST_BUSY,                 // Host requests outstanding
   output logic                  BG_RUN,                    // Background function may run
   output logic      [N_BG-1:0]  BG_SEL,                    // One-hot function selected
   output logic                  BG_SUSPEND,                // Function parked for host
   output logic                  LOW_POWER,                 // In a timer low-power condition
   output logic                  PWR_ENTER,                 // Pulse: enter timer condition
   output logic      [N_TMR-1:0] PWR_SEL,                   // One-hot timer whose condition
   output logic                  PWR_WAKE                   // Pulse: leave low power
);
   // Refuse sizes the logic cannot serve
   if (N_BG < 1 || N_BG > 16 || N_TMR < 1 || N_TMR > 16) begin : g_chk
      $error("bvlp_arbiter: N_BG and N_TMR must lie in 1..16");
   end

   // Lowest set bit as a one-hot vector; the run order is free, so fixed order is simplest
   function automatic logic [N_BG-1:0] first_one(input logic [N_BG-1:0] v);
      logic [N_BG-1:0] r;
      logic            hit;
      r   = '0;
      hit = 1'b0;
      for (int i = 0; i < N_BG; i++) begin
         if (v[i] && !hit) begin
            r[i] = 1'b1;
            hit  = 1'b1;
         end
      end
      return r;
   endfunction

   bvlp_pkg::bvlp_state_t state_ff, nxt_state;   // Arbiter state
   logic [1:0]       code_ff,    nxt_code;       // Held precedence code
   logic [N_BG-1:0]  pend_ff,    nxt_pend;       // Initiated, unfinished functions
   logic [N_BG-1:0]  cur_ff,     nxt_cur;        // Function currently selected
   logic [N_TMR-1:0] exp_ff,     nxt_exp;        // Latched expired timers
   logic [N_TMR-1:0] psel_ff,    nxt_psel;       // Timer of the entered condition
   logic             run_ff,     nxt_run;        // Output copy of running state
   logic             susp_ff,    nxt_susp;       // Output copy of suspended state
   logic             low_ff,     nxt_low;        // Output copy of low-power state
   logic             enter_ff,   nxt_enter;      // Entry pulse
   logic             wake_ff,    nxt_wake;       // Wake pulse
   logic [N_TMR-1:0] tmr_grant;                  // Highest expired timer
   logic             tmr_any;                    // Any timer expired
   logic             lp_prio;                    // Low power wins
   logic             bg_prio;                    // Background wins
   logic [N_BG-1:0]  remain;                     // Pending minus finished function

   // Only the low-power code changes policy; zero and reserved fall back
   assign lp_prio = (code_ff == bvlp_pkg::CODE_LP_FIRST);
   assign bg_prio = !lp_prio;
   assign remain  = pend_ff & ~cur_ff;

   // Highest-priority expired timer
   bvlp_prio_pick #(
      .W     (N_TMR)
   ) u_tmr_pick (
      .req   (exp_ff),
      .grant (tmr_grant),
      .any   (tmr_any)
   );

   // Next-state logic for the whole arbiter
   always_comb begin
      nxt_state = state_ff;
      nxt_code  = BG_POWER_PRECEDENCE_CODE;
      // New triggers are latched even in the cycle a bit clears, so none is lost
      nxt_pend  = pend_ff | (BG_TRIG & BG_EN);
      nxt_exp   = exp_ff | TMR_EXPIRED;
      nxt_cur   = cur_ff;
      nxt_psel  = psel_ff;
      nxt_enter = 1'b0;
      nxt_wake  = 1'b0;
      case (state_ff)
         bvlp_pkg::ST_ACTIVE: begin
            if (HOST_CMD) begin
               // Host work first, nothing starts
               nxt_state = bvlp_pkg::ST_ACTIVE;
            end else if (|pend_ff && bg_prio) begin
               // Pending work holds off any expired timer
               nxt_state = bvlp_pkg::ST_BGRUN;
               nxt_cur   = first_one(pend_ff);
            end else if (tmr_any && !HOST_BUSY) begin
               // Enter the highest expired timer's condition
               nxt_state = bvlp_pkg::ST_LOWPWR;
               nxt_enter = 1'b1;
               nxt_psel  = tmr_grant;
               nxt_exp   = TMR_EXPIRED;
            end else if (|pend_ff && !HOST_BUSY) begin
               // Low-power priority: powered for other reasons and host idle
               nxt_state = bvlp_pkg::ST_BGRUN;
               nxt_cur   = first_one(pend_ff);
            end
         end
         bvlp_pkg::ST_LOWPWR: begin
            if (HOST_CMD) begin
               // A host access always brings the device up
               nxt_state = bvlp_pkg::ST_ACTIVE;
               nxt_wake  = 1'b1;
            end else if (bg_prio && |pend_ff) begin
               // Background priority leaves the timer condition
               nxt_state = bvlp_pkg::ST_BGRUN;
               nxt_wake  = 1'b1;
               nxt_cur   = first_one(pend_ff);
            end
            // Low-power priority stays put for background work
         end
         bvlp_pkg::ST_BGRUN: begin
            if (lp_prio && tmr_any) begin
               // Park the function, it stays pending, then enter the condition
               nxt_state = bvlp_pkg::ST_LOWPWR;
               nxt_enter = 1'b1;
               nxt_psel  = tmr_grant;
               nxt_exp   = TMR_EXPIRED;
            end else if (HOST_CMD) begin
               nxt_state = bvlp_pkg::ST_BGSUSP;
            end else if (BG_DONE) begin
               nxt_pend = remain | (BG_TRIG & BG_EN);
               if (|remain) begin
                  nxt_cur = first_one(remain);
               end else begin
                  // All work done; timers are checked from the active state
                  nxt_state = bvlp_pkg::ST_ACTIVE;
                  nxt_cur   = '0;
               end
            end
         end
         bvlp_pkg::ST_BGSUSP: begin
            if (lp_prio && tmr_any) begin
               nxt_state = bvlp_pkg::ST_LOWPWR;
               nxt_enter = 1'b1;
               nxt_psel  = tmr_grant;
               nxt_exp   = TMR_EXPIRED;
            end else if (!HOST_CMD && !HOST_BUSY) begin
               // Resume once the host is served
               nxt_state = bvlp_pkg::ST_BGRUN;
            end
         end
         default: begin
            nxt_state = bvlp_pkg::ST_ACTIVE;
         end
      endcase
      nxt_run  = (nxt_state == bvlp_pkg::ST_BGRUN);
      nxt_susp = (nxt_state == bvlp_pkg::ST_BGSUSP);
      nxt_low  = (nxt_state == bvlp_pkg::ST_LOWPWR);
   end

   // State registers
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_ff <= bvlp_pkg::ST_ACTIVE;
         code_ff  <= bvlp_pkg::CODE_RESET;
         pend_ff  <= '0;
         cur_ff   <= '0;
         exp_ff   <= '0;
         psel_ff  <= '0;
         run_ff   <= 1'b0;
         susp_ff  <= 1'b0;
         low_ff   <= 1'b0;
         enter_ff <= 1'b0;
         wake_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         code_ff  <= nxt_code;
         pend_ff  <= nxt_pend;
         cur_ff   <= nxt_cur;
         exp_ff   <= nxt_exp;
         psel_ff  <= nxt_psel;
         run_ff   <= nxt_run;
         susp_ff  <= nxt_susp;
         low_ff   <= nxt_low;
         enter_ff <= nxt_enter;
         wake_ff  <= nxt_wake;
      end
   end

   assign BG_RUN     = run_ff;
   assign BG_SEL     = cur_ff;
   assign BG_SUSPEND = susp_ff;
   assign LOW_POWER  = low_ff;
   assign PWR_ENTER  = enter_ff;
   assign PWR_SEL    = psel_ff;
   assign PWR_WAKE   = wake_ff;

   // Checks on the arbiter's own outputs
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_low_with_work;
      low_ff && bg_prio && |pend_ff && !HOST_CMD;
   endsequence
   sequence s_woken_to_run;
      wake_ff && run_ff;
   endsequence

   property p_code_held;
      ##1 code_ff == $past(BG_POWER_PRECEDENCE_CODE);
   endproperty
   a_code_held: assert property (p_code_held)
      else $error("precedence code not held");

   property p_bg_wake;
      s_low_with_work |=> s_woken_to_run;
   endproperty
   a_bg_wake: assert property (p_bg_wake)
      else $error("background priority did not wake for work");

   property p_host_suspend;
      (run_ff && HOST_CMD && !(lp_prio && tmr_any)) |=> (susp_ff && !run_ff);
   endproperty
   a_host_suspend: assert property (p_host_suspend)
      else $error("host command did not suspend work");

   property p_pending_runs;
      (state_ff == bvlp_pkg::ST_ACTIVE && bg_prio && |pend_ff && !HOST_CMD)
         |=> (run_ff && $onehot(BG_SEL));
   endproperty
   a_pending_runs: assert property (p_pending_runs)
      else $error("initiated work not started");

   property p_enter_after_work;
      (state_ff == bvlp_pkg::ST_ACTIVE && pend_ff == '0 && tmr_any && !HOST_CMD && !HOST_BUSY)
         |=> (enter_ff && low_ff && PWR_SEL == $past(tmr_grant));
   endproperty
   a_enter_after_work: assert property (p_enter_after_work)
      else $error("expired timer condition not entered");

   property p_bg_no_early_enter;
      (enter_ff && $past(bg_prio)) |-> ($past(pend_ff) == '0 && !$past(run_ff));
   endproperty
   a_bg_no_early_enter: assert property (p_bg_no_early_enter)
      else $error("entered low power with work pending");

   property p_lp_stays_low;
      (low_ff && lp_prio && !HOST_CMD) |=> (!wake_ff && low_ff);
   endproperty
   a_lp_stays_low: assert property (p_lp_stays_low)
      else $error("low-power priority woke for work");

   property p_lp_start_idle;
      (run_ff && !$past(run_ff) && $past(lp_prio)) |-> !$past(HOST_BUSY) && !$past(low_ff);
   endproperty
   a_lp_start_idle: assert property (p_lp_start_idle)
      else $error("low-power priority started work while busy");

   property p_lp_timer_wins;
      (run_ff && lp_prio && tmr_any) |=> (enter_ff && !run_ff ##1 !enter_ff);
   endproperty
   a_lp_timer_wins: assert property (p_lp_timer_wins)
      else $error("timer did not suspend work");
endmodule

/* File: src/bvlp_pkg.sv */
// Shared constants and types for the background versus low-power arbiter, plus its timer picker
package bvlp_pkg;
   // Precedence code values
   localparam logic [1:0] CODE_BG_DEFAULT = 2'h0;   // Zero code, acts as background priority
   localparam logic [1:0] CODE_BG_FIRST   = 2'h1;   // Background work beats low power
   localparam logic [1:0] CODE_LP_FIRST   = 2'h2;   // Low power beats background work
   localparam logic [1:0] CODE_RESERVED   = 2'h3;   // Reserved, no behaviour of its own
   localparam logic [1:0] CODE_RESET      = 2'h0;   // Code value held after reset
   localparam logic [7:0] CTRL_PAGE_CODE  = 8'h1a;  // Settings page that carries the code
   // Default sizes
   localparam int         BG_FUNCS_DEF    = 2;      // Background scan and device maintenance
   localparam int         TIMERS_DEF      = 5;      // Idle a, b, c and standby y, z timers

   // Arbiter states, one-hot
   typedef enum logic [3:0] {
      ST_ACTIVE = 4'h1,   // Powered, no background work running
      ST_LOWPWR = 4'h2,   // In a timer-entered low-power condition
      ST_BGRUN  = 4'h4,   // Running one background function
      ST_BGSUSP = 4'h8    // Background function parked for host work
   } bvlp_state_t;
endpackage

// Picks the highest-priority request; bit 0 has the highest priority
module bvlp_prio_pick #(
   parameter int W = 5                 // Number of requesters
) (
   input  wire logic [W-1:0] req,      // Request vector
   output logic      [W-1:0] grant,    // One-hot grant, zero when no request
   output logic              any       // At least one request
);
   logic [W:0] seen;                   // Prefix OR of higher-priority requests

   assign seen[0] = 1'b0;
   // Prefix chain, one stage per requester
   for (genvar g = 0; g < W; g++) begin : g_pick
      assign seen[g+1] = seen[g] | req[g];
      assign grant[g]  = req[g] & ~seen[g];
   end
   assign any = seen[W];
endmodule

/* File: testbench/bvlp_host_model.sv */
// Host application client model that issues commands of a chosen length
module bvlp_host_model (
   input  wire logic       clk,        // Bench clock
   input  wire logic       arst_n,     // Async reset, active low
   input  wire logic       go,         // Start one command
   input  wire logic [3:0] len,        // Cycles the command stays outstanding
   output logic            host_cmd,   // Command being processed
   output logic            host_busy   // Requests outstanding
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] left_ff;                // Cycles still outstanding

   // Busy drops with the command, so the device sees no stale request afterwards
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         left_ff <= 4'h0;
      end else if (go) begin
         left_ff <= len;
      end else if (left_ff != 4'h0) begin
         left_ff <= left_ff - 4'h1;
      end
   end
   assign host_cmd  = (left_ff != 4'h0);
   assign host_busy = (left_ff != 4'h0);
endmodule

/* File: testbench/bvlp_arbiter_test.sv */
// Self-checking bench for the background versus low-power arbiter
module bvlp_arbiter_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;           // 200 MHz clock
   logic       arst_n = 1'b0;        // Reset, active low
   logic [1:0] code = 2'h0;          // Precedence code
   logic [1:0] trig = 2'h0;          // Background triggers
   logic [1:0] en = 2'h0;            // Background enables
   logic       done = 1'b0;          // Function finished
   logic [4:0] tmr = 5'h0;           // Timer expiries
   logic       go = 1'b0;            // Host command start
   logic [3:0] len = 4'h4;           // Host command length
   logic       host_cmd, host_busy;  // From host model
   logic       run, susp, lowp;      // Level outputs
   logic       enter, wake;          // Pulse outputs
   logic [1:0] sel;                  // Selected function
   logic [4:0] psel;                 // Timer of entered condition
   int         miscompares = 0;      // Mismatch count
   int         checked = 0;          // Comparison count

   always #2.5 clk = ~clk;

   bvlp_arbiter u_dut (.CLK(clk), .ARST_N(arst_n), .BG_POWER_PRECEDENCE_CODE(code),
      .BG_TRIG(trig), .BG_EN(en), .BG_DONE(done), .TMR_EXPIRED(tmr), .HOST_CMD(host_cmd),
      .HOST_BUSY(host_busy), .BG_RUN(run), .BG_SEL(sel), .BG_SUSPEND(susp),
      .LOW_POWER(lowp), .PWR_ENTER(enter), .PWR_SEL(psel), .PWR_WAKE(wake));

   bvlp_host_model u_host (.clk(clk), .arst_n(arst_n), .go(go), .len(len),
      .host_cmd(host_cmd), .host_busy(host_busy));

   // Steps to a rising edge, where stimulus changes by non-blocking assignment
   task ed(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Moves to the falling edge, where outputs have settled
   task ck;
      @(negedge clk);
   endtask
   task cmp_bit(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask
   task cmp_vec(input string name, input logic [4:0] exp, input logic [4:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task end_sim;
      if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Background priority: two triggers, timer during work, wake and host suspend
   task s_bg_first(input logic [1:0] c);
      ed(1); code <= c;
      ed(2); en <= 2'h3; trig <= 2'h3;
      ed(1); trig <= 2'h0;
      ed(2); ck; cmp_vec("bg_sel first", 5'h01, {3'h0, sel});
      ed(1); done <= 1'b1; tmr <= 5'h06;
      ed(1); done <= 1'b0; tmr <= 5'h00;
      ed(1); ck; cmp_vec("bg_sel second", 5'h02, {3'h0, sel});
      cmp_bit("pwr_enter during work", 1'b0, enter);
      ed(1); done <= 1'b1;
      ed(1); done <= 1'b0;
      // Last completion is taken at this edge, so the state is already active
      ck; cmp_bit("bg_run after all done", 1'b0, run);
      cmp_bit("low_power before enter", 1'b0, lowp);
      ed(1); ck; cmp_bit("pwr_enter", 1'b1, enter);
      cmp_vec("pwr_sel highest expired", 5'h02, psel);
      cmp_bit("low_power entered", 1'b1, lowp);
      ed(1); trig <= 2'h2;
      ed(1); trig <= 2'h0;
      // Wake is a one-cycle pulse: look in the cycle right after the decision
      ed(1); ck; cmp_bit("pwr_wake", 1'b1, wake);
      cmp_bit("bg_run on wake", 1'b1, run);
      cmp_bit("low_power on wake", 1'b0, lowp);
      ed(1); go <= 1'b1;
      ed(1); go <= 1'b0;
      ed(2); ck; cmp_bit("bg_suspend", 1'b1, susp);
      cmp_bit("bg_run parked", 1'b0, run);
      ed(1); ck; cmp_vec("bg_sel kept", 5'h02, {3'h0, sel});
      cmp_bit("bg_suspend held", 1'b1, susp);
      ed(3); ck; cmp_bit("bg_run resumed", 1'b1, run);
      cmp_bit("bg_suspend released", 1'b0, susp);
      ed(1); done <= 1'b1;
      ed(1); done <= 1'b0;
      ed(1); ck; cmp_vec("bg_sel cleared", 5'h00, {3'h0, sel});
   endtask

   // Low-power priority: no wake for work, work after host idle, timer preempts
   task s_lp_first;
      ed(1); code <= 2'h2;
      ed(2); tmr <= 5'h14;
      ed(1); tmr <= 5'h00;
      ed(2); ck; cmp_vec("pwr_sel lp", 5'h04, psel);
      ed(1); trig <= 2'h1;
      ed(1); trig <= 2'h0;
      ed(4); ck; cmp_bit("low_power kept", 1'b1, lowp);
      cmp_bit("bg_run in low power", 1'b0, run);
      ed(1); go <= 1'b1;
      ed(1); go <= 1'b0;
      ed(4); ck; cmp_bit("bg_run while host busy", 1'b0, run);
      ed(3); ck; cmp_bit("bg_run after host idle", 1'b1, run);
      ed(1); tmr <= 5'h01;
      ed(1); tmr <= 5'h00;
      ed(1); ck; cmp_bit("pwr_enter preempt", 1'b1, enter);
      cmp_vec("pwr_sel preempt", 5'h01, psel);
      cmp_bit("bg_run preempted", 1'b0, run);
   endtask

   // Hang guard well beyond the roughly 110 cycles the tests need
   initial begin
      #20000;
      miscompares++;
      end_sim();
   end

   initial begin
      ed(6); arst_n <= 1'b1;
      ck; cmp_vec("pwr_sel reset", 5'h00, psel);
      cmp_bit("bg_run reset", 1'b0, run);
      s_bg_first(2'h0);
      s_bg_first(2'h1);
      s_bg_first(2'h3);
      s_lp_first();
      end_sim();
   end
endmodule
